// ---- logic/stlc_pkg.sv ----
// Package for the serial transmit link layer control block.
// Assumes a single 25 MHz clock domain and an Avalon-MM register slave.
package stlc_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [11:0] TX_LINK_LAYER_CONTROL_IDX = 12'h571;
  localparam logic [11:0] SYNC_INPUT_CONTROL_IDX    = 12'h572;
  localparam logic [11:0] LINK_STATUS_IDX           = 12'h578;
  localparam logic [13:0] TX_LINK_LAYER_CONTROL_ADDR = {TX_LINK_LAYER_CONTROL_IDX, 2'b00};
  localparam logic [13:0] SYNC_INPUT_CONTROL_ADDR    = {SYNC_INPUT_CONTROL_IDX, 2'b00};
  localparam logic [13:0] LINK_STATUS_ADDR           = {LINK_STATUS_IDX, 2'b00};
  // Field positions of the link layer control register
  localparam int CTL_STANDBY_SEL_BIT = 7;
  localparam int CTL_TAIL_PN_BIT     = 6;
  localparam int CTL_LONG_TPL_BIT    = 5;
  localparam int CTL_LANE_SYNC_BIT   = 4;
  localparam int CTL_ILAS_MODE_HI    = 3;
  localparam int CTL_ILAS_MODE_LO    = 2;
  localparam int CTL_FRAME_ALIGN_CHAR_INSERT_DIS_BIT    = 1;
  localparam int CTL_POWER_DOWN_BIT  = 0;
  // Field positions of the sync input control register
  localparam int SYN_CTL_HI     = 7;
  localparam int SYN_CTL_LO     = 6;
  localparam int SYN_INVERT_BIT = 5;
  localparam int SYN_TYPE_BIT   = 4;
  localparam logic [7:0] SYN_WRITE_MASK = 8'hf7;
  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h14;
  localparam logic [7:0] SYN_RESET = 8'h00;
  // Field encodings
  localparam logic [1:0] ILAS_OFF    = 2'h0;
  localparam logic [1:0] ILAS_ON     = 2'h1;
  localparam logic [1:0] ILAS_REPEAT = 2'h3;
  localparam logic [1:0] SYN_NORMAL    = 2'h0;
  localparam logic [1:0] SYN_FORCE_CGS = 2'h2;
  localparam logic [1:0] SYN_FORCE_DAT = 2'h3;
  // Control characters (8-bit values with k flag)
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_4 = 8'h9c;
  // Frame and multiframe geometry
  localparam int FRAME_OCTETS      = 4;
  localparam int FRAMES_PER_MULTI  = 4;
  localparam int ILAS_MULTIFRAMES  = 4;
  localparam int FIFO_DEPTH        = 8;
  // Answer latency: waitrequest is high for exactly one cycle of each access
  localparam int BUS_WAIT_CYCLES = 1;
  // Link state one-hot codes
  typedef enum logic [4:0] {
    STLC_ST_OFF  = 5'h01,
    STLC_ST_SBY  = 5'h02,
    STLC_ST_CGS  = 5'h04,
    STLC_ST_ILAS = 5'h08,
    STLC_ST_DATA = 5'h10
  } stlc_state_t;
endpackage

// ---- logic/stlc_fifo.sv ----
// Sample FIFO with valid/ready on both sides.
// Assumes synchronous use on one clock; width and depth are parameters.
`timescale 1ns/1ps
module stlc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // Drain side
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Handshake terms
  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];

  // Storage write
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ---- logic/stlc_top.sv ----
// Serial transmit link layer control: registers, sync request handling and
// one octet selection broadcast to all lanes (samples, /K/ characters, alignment sequence).
// Assumes converter samples arrive as octets with valid/ready, one clock.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module stlc_top #(
  parameter int LANES = 2
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_sys_rst,
  // Avalon-MM register slave
  input  wire logic [13:0]          i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Sync request, two receivers
  input  wire logic                 i_sync_request_diff,
  input  wire logic                 i_sync_request_cmos,
  input  wire logic                 i_standby,
  // Converter sample octets
  input  wire logic [7:0]           i_smp_data,
  input  wire logic                 i_smp_valid,
  output logic                      o_smp_ready,
  // Lane octets
  output logic [LANES*8-1:0]        o_lane_data,
  output logic [LANES-1:0]          o_lane_k,
  output logic                      o_lane_valid,
  output logic                      o_link_rst,
  output logic                      o_diff_rx_en
);
  logic [7:0]                ctl_reg;
  logic [7:0]                syn_reg;
  logic                      ack_reg;
  logic [31:0]               rdata_reg;
  stlc_pkg::stlc_state_t     state_reg;
  stlc_pkg::stlc_state_t     state_next;
  logic [1:0]                oct_reg;
  logic [1:0]                frm_reg;
  logic [1:0]                mf_reg;
  logic [7:0]                tpl_reg;
  logic [7:0]                sample_q;
  logic                      sample_v;
  logic                      fifo_pop;
  logic                      sync_raw;
  logic                      sync_req_n;
  logic                      want_cgs;
  logic                      power_down;
  logic [1:0]                ilas_mode;
  logic                      frame_end;
  logic                      multi_end;
  logic [7:0]                oct_data;
  logic                      oct_k;
  logic [7:0]                prev_oct_reg;
  logic                      bus_hit;

  // Field decode
  assign power_down = ctl_reg[stlc_pkg::CTL_POWER_DOWN_BIT];
  assign ilas_mode  = ctl_reg[stlc_pkg::CTL_ILAS_MODE_HI:stlc_pkg::CTL_ILAS_MODE_LO];
  assign o_link_rst = power_down;

  // Bus: one wait cycle, then answer
  assign bus_hit = (i_avs_read || i_avs_write) && !ack_reg;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
  assign o_avs_readdata    = rdata_reg;

  // Acknowledge toggle and read data capture
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_hit;
      if (bus_hit && i_avs_read) begin
        case (i_avs_address)
          stlc_pkg::TX_LINK_LAYER_CONTROL_ADDR: rdata_reg <= {24'h000000, ctl_reg};
          stlc_pkg::SYNC_INPUT_CONTROL_ADDR:    rdata_reg <= {24'h000000, syn_reg};
          stlc_pkg::LINK_STATUS_ADDR:           rdata_reg <= {26'h0000000, sync_req_n, state_reg};
          default:                              rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register writes, taken on the cycle waitrequest falls
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_reg <= stlc_pkg::CTL_RESET;
      syn_reg <= stlc_pkg::SYN_RESET;
    end else if (ack_reg && i_avs_write && i_avs_byteenable[0]) begin
      if (i_avs_address == stlc_pkg::TX_LINK_LAYER_CONTROL_ADDR) begin
        ctl_reg <= i_avs_writedata[7:0];
      end
      if (i_avs_address == stlc_pkg::SYNC_INPUT_CONTROL_ADDR) begin
        syn_reg <= i_avs_writedata[7:0] & stlc_pkg::SYN_WRITE_MASK;
      end
    end
  end

  // Sync request: pick receiver, apply polarity, then override
  assign o_diff_rx_en = !syn_reg[stlc_pkg::SYN_TYPE_BIT];
  assign sync_raw = syn_reg[stlc_pkg::SYN_TYPE_BIT] ? i_sync_request_cmos
                                                    : i_sync_request_diff;
  assign sync_req_n = sync_raw ^ syn_reg[stlc_pkg::SYN_INVERT_BIT];

  // Whether code group sync is demanded; active-low request assumed
  always_comb begin
    case (syn_reg[stlc_pkg::SYN_CTL_HI:stlc_pkg::SYN_CTL_LO])
      stlc_pkg::SYN_FORCE_CGS: want_cgs = 1'b1;
      stlc_pkg::SYN_FORCE_DAT: want_cgs = 1'b0;
      default:                 want_cgs = !sync_req_n;
    endcase
  end

  // Frame and multiframe position
  assign frame_end = (oct_reg == 2'(stlc_pkg::FRAME_OCTETS-1));
  assign multi_end = frame_end && (frm_reg == 2'(stlc_pkg::FRAMES_PER_MULTI-1));

  // Link state selection
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      stlc_pkg::STLC_ST_OFF: begin
        state_next = stlc_pkg::STLC_ST_CGS;
      end
      stlc_pkg::STLC_ST_SBY: begin
        if (!i_standby) state_next = stlc_pkg::STLC_ST_CGS;
      end
      stlc_pkg::STLC_ST_CGS: begin
        if (!want_cgs && multi_end) begin
          state_next = (ilas_mode == stlc_pkg::ILAS_OFF) ? stlc_pkg::STLC_ST_DATA
                                                         : stlc_pkg::STLC_ST_ILAS;
        end
      end
      stlc_pkg::STLC_ST_ILAS: begin
        if (want_cgs) begin
          state_next = stlc_pkg::STLC_ST_CGS;
        end else if (multi_end && mf_reg == 2'(stlc_pkg::ILAS_MULTIFRAMES-1) &&
                     ilas_mode != stlc_pkg::ILAS_REPEAT) begin
          state_next = stlc_pkg::STLC_ST_DATA;
        end
      end
      stlc_pkg::STLC_ST_DATA: begin
        if (want_cgs) begin
          state_next = stlc_pkg::STLC_ST_CGS;
        end else if (multi_end && ilas_mode == stlc_pkg::ILAS_REPEAT) begin
          // Test mode entered from running data restarts at a multiframe edge
          state_next = stlc_pkg::STLC_ST_ILAS;
        end
      end
      default: state_next = stlc_pkg::STLC_ST_CGS;
    endcase
    if (i_standby && state_reg != stlc_pkg::STLC_ST_OFF) begin
      state_next = stlc_pkg::STLC_ST_SBY;
    end
  end

  // State register; power down holds the link in reset
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= stlc_pkg::STLC_ST_OFF;
    end else if (power_down) begin
      state_reg <= stlc_pkg::STLC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Octet, frame and multiframe counters
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oct_reg <= 2'h0;
      frm_reg <= 2'h0;
      mf_reg  <= 2'h0;
    end else if (power_down || state_reg == stlc_pkg::STLC_ST_OFF) begin
      oct_reg <= 2'h0;
      frm_reg <= 2'h0;
      mf_reg  <= 2'h0;
    end else begin
      oct_reg <= oct_reg + 2'h1;
      if (frame_end) frm_reg <= frm_reg + 2'h1;
      if (state_reg != stlc_pkg::STLC_ST_ILAS) begin
        mf_reg <= 2'h0;
      end else if (multi_end) begin
        mf_reg <= mf_reg + 2'h1;
      end
    end
  end

  // Long transport test sequence counter
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tpl_reg <= 8'h00;
    end else if (state_reg != stlc_pkg::STLC_ST_DATA) begin
      tpl_reg <= 8'h00;
    end else begin
      tpl_reg <= tpl_reg + 8'h01;
    end
  end

  // Sample FIFO; drained only while user data flows
  assign fifo_pop = (state_reg == stlc_pkg::STLC_ST_DATA) && !ctl_reg[stlc_pkg::CTL_LONG_TPL_BIT];
  stlc_fifo #(
    .WIDTH (8),
    .DEPTH (stlc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_data   (i_smp_data),
    .i_in_valid  (i_smp_valid),
    .o_in_ready  (o_smp_ready),
    .o_out_data  (sample_q),
    .o_out_valid (sample_v),
    .i_out_ready (fifo_pop)
  );

  // Octet content for the current position
  always_comb begin
    oct_data = 8'h00;
    oct_k    = 1'b0;
    case (state_reg)
      stlc_pkg::STLC_ST_SBY: begin
        if (ctl_reg[stlc_pkg::CTL_STANDBY_SEL_BIT]) begin
          oct_data = stlc_pkg::K28_5;
          oct_k    = 1'b1;
        end
      end
      stlc_pkg::STLC_ST_CGS: begin
        oct_data = stlc_pkg::K28_5;
        oct_k    = 1'b1;
      end
      stlc_pkg::STLC_ST_ILAS: begin
        if (oct_reg == 2'h0 && frm_reg == 2'h0) begin
          oct_data = stlc_pkg::K28_0;
          oct_k    = 1'b1;
        end else if (multi_end) begin
          oct_data = stlc_pkg::K28_3;
          oct_k    = 1'b1;
        end else if (mf_reg == 2'h1 && frm_reg == 2'h0 && oct_reg == 2'h1) begin
          oct_data = stlc_pkg::K28_4;
          oct_k    = 1'b1;
        end else begin
          oct_data = {6'h00, oct_reg};
        end
      end
      stlc_pkg::STLC_ST_DATA: begin
        if (ctl_reg[stlc_pkg::CTL_LONG_TPL_BIT]) begin
          oct_data = tpl_reg;
        end else begin
          oct_data = sample_v ? sample_q : 8'h00;
        end
        // Alignment character replaces a frame-end octet equal to the last one
        if (!ctl_reg[stlc_pkg::CTL_FRAME_ALIGN_CHAR_INSERT_DIS_BIT] && frame_end && oct_data == prev_oct_reg) begin
          oct_k    = 1'b1;
          oct_data = (multi_end || !ctl_reg[stlc_pkg::CTL_LANE_SYNC_BIT]) ?
                     stlc_pkg::K28_7 : stlc_pkg::K28_3;
          if (multi_end && ctl_reg[stlc_pkg::CTL_LANE_SYNC_BIT]) begin
            oct_data = stlc_pkg::K28_3;
          end
        end
      end
      default: begin
        oct_data = 8'h00;
        oct_k    = 1'b0;
      end
    endcase
  end

  // Previous octet for alignment comparison
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_oct_reg <= 8'h00;
    end else begin
      prev_oct_reg <= oct_data;
    end
  end

  // Lane outputs: same octet broadcast to all lanes
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_lane_data[g*8 +: 8] <= 8'h00;
          o_lane_k[g]           <= 1'b0;
        end else if (power_down) begin
          o_lane_data[g*8 +: 8] <= 8'h00;
          o_lane_k[g]           <= 1'b0;
        end else begin
          o_lane_data[g*8 +: 8] <= oct_data;
          o_lane_k[g]           <= oct_k;
        end
      end
    end
  endgenerate

  // Lane valid flag
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_lane_valid <= 1'b0;
    end else begin
      o_lane_valid <= !power_down && state_reg != stlc_pkg::STLC_ST_OFF;
    end
  end
endmodule

// ---- test/stlc_top_monitor.sv ----
// Checker for the link layer control block, bound to the top ports.
// Assumes one clock and register writes taken when waitrequest is low.
`timescale 1ns/1ps
module stlc_top_monitor #(
  parameter int LANES = 2
) (
  // Clock and reset
  input wire logic               i_ref_clk,
  input wire logic               i_sys_rst,
  // Register bus
  input wire logic [13:0]        i_avs_address,
  input wire logic               i_avs_read,
  input wire logic               i_avs_write,
  input wire logic [31:0]        i_avs_writedata,
  input wire logic [3:0]         i_avs_byteenable,
  input wire logic [31:0]        o_avs_readdata,
  input wire logic               o_avs_waitrequest,
  // Sync request and samples
  input wire logic               i_sync_request_diff,
  input wire logic               i_sync_request_cmos,
  input wire logic               i_standby,
  input wire logic [7:0]         i_smp_data,
  input wire logic               i_smp_valid,
  input wire logic               o_smp_ready,
  // Lanes
  input wire logic [LANES*8-1:0] o_lane_data,
  input wire logic [LANES-1:0]   o_lane_k,
  input wire logic               o_lane_valid,
  input wire logic               o_link_rst,
  input wire logic               o_diff_rx_en
);
  logic [7:0] ctl_reg;
  logic [7:0] syn_reg;
  logic [7:0] run_reg;
  logic       take;
  logic       req_n;
  logic       dem;
  logic [7:0] ln0;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Taken write, selected request and the sync demand it implies
  assign take  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign req_n = (syn_reg[4] ? i_sync_request_cmos : i_sync_request_diff) ^ syn_reg[5];
  assign dem   = !ctl_reg[0] && !i_standby && ((syn_reg[7:6] == stlc_pkg::SYN_NORMAL && !req_n)
                 || syn_reg[7:6] == stlc_pkg::SYN_FORCE_CGS);
  assign ln0   = o_lane_data[7:0];
  // Shadow copy of both control registers
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_reg <= 8'h14;
      syn_reg <= 8'h00;
    end else if (take && i_avs_address == stlc_pkg::TX_LINK_LAYER_CONTROL_ADDR) begin
      ctl_reg <= i_avs_writedata[7:0];
    end else if (take && i_avs_address == stlc_pkg::SYNC_INPUT_CONTROL_ADDR) begin
      syn_reg <= i_avs_writedata[7:0] & stlc_pkg::SYN_WRITE_MASK;
    end
  end
  // Cycles of forced data with no alignment sequence and no standby
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_reg <= 8'h00;
    end else if (take || i_standby || ctl_reg[0] || syn_reg[7:6] != stlc_pkg::SYN_FORCE_DAT
                 || ctl_reg[3:2] != stlc_pkg::ILAS_OFF) begin
      run_reg <= 8'h00;
    end else if (run_reg != 8'hff) begin
      run_reg <= run_reg + 8'h01;
    end
  end
  chk_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  chk_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  chk_read_upper: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_link_reset: assert property (o_link_rst == ctl_reg[0])
    else $error("link reset differs from control bit");
  chk_down_quiet: assert property (o_link_rst [*2] |-> !o_lane_valid)
    else $error("lanes valid while powered down");
  chk_rx_select: assert property (o_diff_rx_en == !syn_reg[4])
    else $error("receiver select differs from type bit");
  chk_sync_demand: assert property (dem [*6] |-> o_lane_valid && o_lane_k[0] && ln0 == stlc_pkg::K28_5)
    else $error("sync demanded but no sync characters");
  chk_standby_zero: assert property ((i_standby && ctl_reg[7:5] == 3'h0) [*4] |->
    o_lane_valid && !o_lane_k[0] && ln0 == 8'h00) else $error("standby not zero samples");
  chk_standby_sync: assert property ((i_standby && ctl_reg[7] && !ctl_reg[0]) [*4] |->
    o_lane_k[0] && ln0 == stlc_pkg::K28_5) else $error("standby not sync characters");
  chk_lanes_same: assert property (o_lane_valid |-> o_lane_data == {LANES{ln0}} && o_lane_k == {LANES{o_lane_k[0]}})
    else $error("lanes differ");
  chk_align_char: assert property (run_reg > 8'd70 && o_lane_k[0] |-> !ctl_reg[1] &&
    (ln0 == stlc_pkg::K28_7 || (ctl_reg[4] && ln0 == stlc_pkg::K28_3))) else $error("bad control character in data");
  // Main scenarios reached
  cov_demand: cover property (dem [*6]);
  cov_align: cover property (run_reg > 8'd70 && o_lane_k[0]);
  cov_standby: cover property (i_standby && o_lane_valid);
endmodule
bind stlc_top stlc_top_monitor #(.LANES(LANES)) u_mon (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_sync_request_diff(i_sync_request_diff),
  .i_sync_request_cmos(i_sync_request_cmos), .i_standby(i_standby), .i_smp_data(i_smp_data),
  .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .o_lane_data(o_lane_data), .o_lane_k(o_lane_k),
  .o_lane_valid(o_lane_valid), .o_link_rst(o_link_rst), .o_diff_rx_en(o_diff_rx_en));

// ---- test/stlc_rx_model.sv ----
// Far-end receiver model: drives the active-low sync request.
// Assumes lane 0 octets and k flag of the transmit block on the same clock.
`timescale 1ns/1ps
module stlc_rx_model (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // Lane 0 and bench commands
  input  wire logic [7:0] i_lane_data,
  input  wire logic       i_lane_k,
  input  wire logic       i_lane_valid,
  input  wire logic       i_demand,
  input  wire logic       i_invert,
  // Sync request pin
  output logic            o_sync_request
);
  logic       sync_n_reg;
  logic [2:0] k_cnt_reg;
  // Hold the request low until four sync characters arrive
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_n_reg <= 1'b0;
      k_cnt_reg  <= 3'h0;
    end else if (i_demand) begin
      sync_n_reg <= 1'b0;
      k_cnt_reg  <= 3'h0;
    end else if (!sync_n_reg && i_lane_valid && i_lane_k && i_lane_data == stlc_pkg::K28_5) begin
      k_cnt_reg <= k_cnt_reg + 3'h1;
      if (k_cnt_reg == 3'h3) begin
        sync_n_reg <= 1'b1;
      end
    end
  end
  // Polarity follows the configured inversion
  assign o_sync_request = sync_n_reg ^ i_invert;
endmodule

// ---- test/serial_tx_link_layer_control_tb.sv ----
// Testbench for the link layer control block with a far-end model.
// Assumes the design package and the bound checker are compiled first.
`timescale 1ns/1ps
module serial_tx_link_layer_control_tb;
  localparam logic [13:0] CTL = stlc_pkg::TX_LINK_LAYER_CONTROL_ADDR;
  localparam logic [13:0] SYN = stlc_pkg::SYNC_INPUT_CONTROL_ADDR;
  logic        i_ref_clk, i_sys_rst, i_avs_read, i_avs_write, i_standby, i_smp_valid, model_n;
  logic [13:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [3:0]  i_avs_byteenable;
  logic [7:0]  i_smp_data, a;
  logic [15:0] o_lane_data;
  logic [1:0]  o_lane_k;
  logic        o_avs_waitrequest, o_smp_ready, o_lane_valid, o_link_rst, o_diff_rx_en;
  logic        demand, invert, diff_own, diff_n, smp_en;
  int          failures, checked, accepted, c;
  always #20 i_ref_clk = ~i_ref_clk;
  stlc_top #(.LANES(2)) i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_sync_request_diff(diff_own ? diff_n : model_n), .i_sync_request_cmos(model_n), .i_standby(i_standby),
    .i_smp_data(i_smp_data), .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .o_lane_data(o_lane_data),
    .o_lane_k(o_lane_k), .o_lane_valid(o_lane_valid), .o_link_rst(o_link_rst), .o_diff_rx_en(o_diff_rx_en));
  stlc_rx_model i_rx (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_lane_data(o_lane_data[7:0]),
    .i_lane_k(o_lane_k[0]), .i_lane_valid(o_lane_valid), .i_demand(demand), .i_invert(invert),
    .o_sync_request(model_n));
  // Sample source: incrementing octets, counting the ones taken
  always @(posedge i_ref_clk) begin
    if (i_smp_valid && o_smp_ready) begin
      accepted <= accepted + 1;
      i_smp_data <= i_smp_data + 8'h01;
    end
    i_smp_valid <= smp_en;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One register access; holds the request until waitrequest is low
  task automatic bus(input logic w, input logic [13:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_avs_address <= ad;
    i_avs_writedata <= {24'h0, d};
    i_avs_read <= !w;
    i_avs_write <= w;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    q = o_avs_readdata;
    if (n >= 20) chk("bus answer", 0, 1);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  // Count lane 0 octets equal to v with flag k; stop at the first unless all
  task automatic scan(input logic [7:0] v, input logic k, input int mx, input bit all);
    c = 0;
    for (int i = 0; i < mx; i++) begin
      @(posedge i_ref_clk);
      if (o_lane_valid === 1'b1 && o_lane_k[0] === k && o_lane_data[7:0] === v) begin
        c++;
        if (!all) break;
      end
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(40 * 8000);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    print_verdict();
  end
  initial begin
    {i_ref_clk, i_avs_read, i_avs_write, i_standby, i_smp_valid, demand, invert, diff_own, diff_n, smp_en} = 0;
    {i_avs_address, i_avs_writedata, accepted, failures, checked} = 0;
    i_avs_byteenable = 4'h1;
    i_smp_data = 8'h40;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    bus(0, CTL, 0); chk("ctl reset", 32'h14, q);
    bus(0, SYN, 0); chk("syn reset", 32'h0, q);
    bus(1, 14'h0000, 8'hff); bus(0, 14'h0000, 0); chk("unmapped", 32'h0, q);
    bus(1, SYN, 8'hff); bus(0, SYN, 0); chk("syn reserved", 32'hf7, q);
    bus(1, SYN, 8'h00);
    scan(stlc_pkg::K28_0, 1, 150, 0); chk("alignment after release", 1, c);
    demand <= 1'b1;
    scan(stlc_pkg::K28_5, 1, 20, 0); chk("sync on demand", 1, c);
    demand <= 1'b0;
    // Inverted, then single-ended request with the pair held demanding
    for (int m = 0; m < 2; m++) begin
      bus(1, SYN, m ? 8'h10 : 8'h20);
      invert <= !m;
      diff_own <= m;
      demand <= 1'b1;
      scan(stlc_pkg::K28_5, 1, 20, 0); chk("sync demand mode", 1, c);
      demand <= 1'b0;
      scan(stlc_pkg::K28_0, 1, 150, 0); chk("release mode", 1, c);
    end
    chk("diff rx off", 0, o_diff_rx_en);
    {invert, diff_own} <= 0;
    bus(1, SYN, 8'h80);
    scan(stlc_pkg::K28_5, 1, 20, 0); chk("forced sync", 1, c);
    bus(0, stlc_pkg::LINK_STATUS_ADDR, 0); chk("status", 32'h24, q);
    smp_en <= 1'b1;
    repeat (30) @(posedge i_ref_clk);
    chk("fifo fill", stlc_pkg::FIFO_DEPTH, accepted);
    chk("fifo refuses", 0, o_smp_ready);
    bus(1, CTL, 8'h12); bus(1, SYN, 8'hc0);
    scan(8'h40, 0, 80, 0); chk("first sample", 1, c);
    @(posedge i_ref_clk); chk("next sample", 32'h41, {24'h0, o_lane_data[7:0]});
    repeat (40) @(posedge i_ref_clk);
    chk("fifo drains", 1, accepted > stlc_pkg::FIFO_DEPTH);
    smp_en <= 1'b0;
    bus(1, CTL, 8'h1c);
    scan(stlc_pkg::K28_0, 1, 200, 1); chk("alignment repeats", 1, c >= 2);
    bus(1, CTL, 8'h32);
    repeat (80) @(posedge i_ref_clk);
    a = o_lane_data[7:0];
    @(posedge i_ref_clk); chk("long test sequence", {24'h0, a + 8'h01}, {24'h0, o_lane_data[7:0]});
    bus(1, CTL, 8'h00);
    repeat (100) @(posedge i_ref_clk);
    bus(1, SYN, 8'h00); bus(1, CTL, 8'h14);
    i_standby <= 1'b1;
    repeat (6) @(posedge i_ref_clk); chk("standby zero", 32'h0, {23'h0, o_lane_k[0], o_lane_data[7:0]});
    bus(1, CTL, 8'h94);
    repeat (6) @(posedge i_ref_clk); chk("standby sync", 32'h1bc, {23'h0, o_lane_k[0], o_lane_data[7:0]});
    i_standby <= 1'b0;
    bus(1, CTL, 8'h15);
    repeat (4) @(posedge i_ref_clk); chk("power down", 32'h2, {30'h0, o_link_rst, o_lane_valid});
    bus(1, CTL, 8'h14);
    repeat (4) @(posedge i_ref_clk); chk("power up", 32'h1, {30'h0, o_link_rst, o_lane_valid});
    print_verdict();
  end
endmodule
